// [src/aee_map.vh]
// constants for the exception entry unit: vectors, modes, causes, map
// assumes a 26-bit address core and a 32-bit AXI4-Lite register bus
// Function
// RULE1 - memory manager raises abort when the current access cannot complete
// RULE2 - abort input is sampled at the end of each bus cycle's first phase
// RULE3 - fetch abort tags the instruction; trap taken when it reaches execution
// RULE4 - a tagged instruction flushed before execution causes no trap
// RULE5 - data abort on single load, store or swap leaves state untouched
// RULE6 - data abort on multiple transfer completes it with base write-back
// RULE7 - after a data abort every further register write is suppressed
// RULE8 - abort during an internal cycle without memory access is ignored
// RULE9 - reset saves status word to supervisor link, both masks, vector zero
// RULE10 - undefined instruction enters supervisor, normal mask, vector 4
// RULE11 - software trap enters supervisor, normal mask, vector 8
// RULE12 - data abort enters supervisor, normal mask, vector 0x10
// RULE13 - prefetch abort enters supervisor like data abort, vector 0x0C
// RULE14 - address exception turns stores into loads, completes, then enters
// RULE15 - address exception saves link, sets normal mask, vector 0x14
// RULE16 - normal interrupt saves to interrupt link, interrupt mode, vector 0x18
// RULE17 - fast interrupt saves to fast link, fast mode, both masks, 0x1C
// RULE18 - undefined and software trap links point to the following instruction
// RULE19 - data abort link lies two words past the aborted instruction
// RULE20 - data address illegal when any of its top six bits is one
// RULE21 - abort input disregarded when the computed address is illegal
// RULE22 - fixed priority: reset, address/data, fast, normal, prefetch, undef/swi
// RULE23 - mode bits use four distinct codes matching banked register selection
`ifndef AEE_MAP_VH
`define AEE_MAP_VH

`define AEE_VEC_RESET 26'h0000000
`define AEE_VEC_UNDEF 26'h0000004
`define AEE_VEC_SWI   26'h0000008
`define AEE_VEC_PABT  26'h000000C
`define AEE_VEC_DABT  26'h0000010
`define AEE_VEC_ADDR  26'h0000014
`define AEE_VEC_IRQ   26'h0000018
`define AEE_VEC_FIQ   26'h000001C

`define AEE_MODE_USR 2'h0
`define AEE_MODE_FIQ 2'h1
`define AEE_MODE_IRQ 2'h2
`define AEE_MODE_SVC 2'h3

`define AEE_PSR_I     27
`define AEE_PSR_F     26
`define AEE_PC_HI     25
`define AEE_PC_LO     2
`define AEE_MODE_HI   1
`define AEE_MODE_LO   0
`define AEE_ADDR_TOP  31
`define AEE_ADDR_BOT  26

`define AEE_CAUSE_NONE  4'h0
`define AEE_CAUSE_RESET 4'h1
`define AEE_CAUSE_UNDEF 4'h2
`define AEE_CAUSE_SWI   4'h3
`define AEE_CAUSE_PABT  4'h4
`define AEE_CAUSE_DABT  4'h5
`define AEE_CAUSE_ADDR  4'h6
`define AEE_CAUSE_IRQ   4'h7
`define AEE_CAUSE_FIQ   4'h8

`define AEE_PC_ONE    24'h000001

`define AEE_OFF_CTRL   4'h0
`define AEE_OFF_STATUS 4'h4
`define AEE_OFF_LINK   4'h8
`define AEE_RESP_OKAY  2'h0
`define AEE_RESP_DECERR 2'h3

`define AEE_CTRL_I    0
`define AEE_CTRL_F    1
`define AEE_CTRL_M_LO 2
`define AEE_CTRL_M_HI 3
`define AEE_ST_CAUSE_HI 3
`define AEE_ST_CAUSE_LO 0
`define AEE_ST_ADDR   4
`define AEE_ST_DABT   5
`define AEE_ST_FIQ    6
`define AEE_ST_IRQ    7
`define AEE_ST_M_LO   8
`define AEE_ST_M_HI   9
`define AEE_ST_I      10
`define AEE_ST_F      11

`endif

// [src/aee_pin_sync.v]
// three-stage synchroniser for an asynchronous pin
// assumes one clock; output changes once stages two and three agree
`timescale 1ns/1ps
module aee_pin_sync (
	input  wire core_clk,  // processor clock
	input  wire nrst,      // async reset, active low
	input  wire pinIn,     // raw pin level
	output reg  levelOut   // filtered level
);
	reg stage1;
	reg stage2;
	reg stage3;

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stage1   <= 1'b1;
			stage2   <= 1'b1;
			stage3   <= 1'b1;
			levelOut <= 1'b1;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				levelOut <= stage3;
			end
		end
	end
endmodule // aee_pin_sync

// [src/aee_exception_entry.v]
// exception entry unit: abort sampling, trap priority, link/mode/vector entry
// assumes the pipeline marks bus phases, instruction ends and data addresses
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "aee_map.vh"
module aee_exception_entry (
	input  wire        core_clk,      // processor clock, 10 MHz
	input  wire        nrst,          // async reset, active low
	input  wire [3:0]  s_axi_awaddr,  // write address
	input  wire        s_axi_awvalid, // write address valid
	output reg         s_axi_awready, // write address ready
	input  wire [31:0] s_axi_wdata,   // write data
	input  wire [3:0]  s_axi_wstrb,   // write byte strobes
	input  wire        s_axi_wvalid,  // write data valid
	output reg         s_axi_wready,  // write data ready
	output reg  [1:0]  s_axi_bresp,   // write response
	output reg         s_axi_bvalid,  // write response valid
	input  wire        s_axi_bready,  // write response ready
	input  wire [3:0]  s_axi_araddr,  // read address
	input  wire        s_axi_arvalid, // read address valid
	output reg         s_axi_arready, // read address ready
	output reg  [31:0] s_axi_rdata,   // read data
	output reg  [1:0]  s_axi_rresp,   // read response
	output reg         s_axi_rvalid,  // read data valid
	input  wire        s_axi_rready,  // read data ready
	input  wire        fiqPinN,       // fast interrupt pin, active low
	input  wire        irqPinN,       // normal interrupt pin, active low
	input  wire        abortIn,       // abort from memory manager
	input  wire        phase1End,     // end of first phase of a bus cycle
	input  wire        cycleFetch,    // current bus cycle is a fetch
	input  wire        cycleData,     // current bus cycle is a data access
	input  wire        pipeAdvance,   // decode slot moves to execute
	input  wire        pipeFlush,     // pipeline discarded (taken branch)
	input  wire        execEnd,       // last cycle of executing instruction
	input  wire        classSingle,   // load_single, store_single, swap_word
	input  wire        classMultiple, // load_multiple or store_multiple
	input  wire        undefInstr,    // no coprocessor accepted instruction
	input  wire        swiInstr,      // software_trap_instr executing
	input  wire        addrValid,     // computed data address present
	input  wire [31:0] dataAddr,      // computed 32-bit data address
	input  wire [31:0] cswIn,         // counter_status_word, pc = instr + 8
	output reg         execInvalid,   // instruction in execute was abort-tagged
	output reg         suppressWrites, // block register writes
	output reg         baseWbAllow,   // base write-back still allowed
	output reg         storeToLoad,   // convert store into load
	output reg         linkWrite,     // write link_register, one cycle
	output reg  [1:0]  linkBank,      // mode bank of link_register written
	output reg  [31:0] linkValue,     // value written to link_register
	output reg         pcLoad,        // force counter, one cycle
	output reg  [25:0] pcValue,       // vector byte address
	output reg  [1:0]  modeOut,       // current mode_bits
	output reg         iMask,         // normal interrupt disable
	output reg         fMask          // fast interrupt disable
);
	localparam ST_RESET = 3'b001;
	localparam ST_RUN   = 3'b010;
	localparam ST_ENTER = 3'b100;

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg         tagDecode;
	reg         addrExc;
	reg         dataAbort;
	reg  [3:0]  lastCause;
	reg  [3:0]  cause;
	reg         awHeld;
	reg         wHeld;
	reg  [3:0]  awAddrQ;
	reg  [31:0] wDataQ;
	reg  [3:0]  wStrbQ;
	wire        fiqLevelN;
	wire        irqLevelN;
	wire        addrIllegal;
	wire        abortSample;
	wire        dataAbortNow;
	wire        dataAbortAny;
	wire        fiqReq;
	wire        irqReq;

	aee_pin_sync u_fiqSync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.pinIn    (fiqPinN),
		.levelOut (fiqLevelN)
	);

	aee_pin_sync u_irqSync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.pinIn    (irqPinN),
		.levelOut (irqLevelN)
	);

	// subtract whole words from the pc field of the status word
	function [31:0] linkFor;
		input [31:0] csw;
		input [3:0]  why;
		reg   [23:0] pcf;
		begin
			pcf = csw[`AEE_PC_HI:`AEE_PC_LO];
			linkFor = csw;
			case (why)
				`AEE_CAUSE_UNDEF, `AEE_CAUSE_SWI, `AEE_CAUSE_PABT: begin
					linkFor[`AEE_PC_HI:`AEE_PC_LO] = pcf - `AEE_PC_ONE; // RULE18
				end
				default: linkFor = csw; // RULE19
			endcase
		end
	endfunction

	function [25:0] vectorFor;
		input [3:0] why;
		begin
			case (why)
				`AEE_CAUSE_UNDEF: vectorFor = `AEE_VEC_UNDEF; // RULE10
				`AEE_CAUSE_SWI:   vectorFor = `AEE_VEC_SWI; // RULE11
				`AEE_CAUSE_PABT:  vectorFor = `AEE_VEC_PABT; // RULE13
				`AEE_CAUSE_DABT:  vectorFor = `AEE_VEC_DABT; // RULE12
				`AEE_CAUSE_ADDR:  vectorFor = `AEE_VEC_ADDR; // RULE15
				`AEE_CAUSE_IRQ:   vectorFor = `AEE_VEC_IRQ; // RULE16
				`AEE_CAUSE_FIQ:   vectorFor = `AEE_VEC_FIQ; // RULE17
				default:          vectorFor = `AEE_VEC_RESET; // RULE9
			endcase
		end
	endfunction

	function [1:0] modeFor;
		input [3:0] why;
		begin
			case (why)
				`AEE_CAUSE_IRQ: modeFor = `AEE_MODE_IRQ; // RULE23
				`AEE_CAUSE_FIQ: modeFor = `AEE_MODE_FIQ;
				default:        modeFor = `AEE_MODE_SVC;
			endcase
		end
	endfunction

	// the memory manager can drive abortIn in internal cycles as well as for failed accesses
	assign addrIllegal  = addrValid &&
		(|dataAddr[`AEE_ADDR_TOP:`AEE_ADDR_BOT]); // RULE20
	assign abortSample  = phase1End && abortIn; // RULE1 RULE2
	assign dataAbortNow = abortSample && cycleData &&
		!addrIllegal && !addrExc; // RULE8 RULE21
	assign dataAbortAny = dataAbort || dataAbortNow;
	assign fiqReq       = !fiqLevelN && !fMask;
	assign irqReq       = !irqLevelN && !iMask;

	// fixed priority of simultaneous exceptions
	always @* begin
		cause = `AEE_CAUSE_NONE;
		if (addrExc || addrIllegal) begin
			cause = `AEE_CAUSE_ADDR; // RULE22
		end else if (dataAbortAny) begin
			cause = `AEE_CAUSE_DABT;
		end else if (fiqReq) begin
			cause = `AEE_CAUSE_FIQ;
		end else if (irqReq) begin
			cause = `AEE_CAUSE_IRQ;
		end else if (execInvalid) begin
			cause = `AEE_CAUSE_PABT; // RULE3
		end else if (undefInstr) begin
			cause = `AEE_CAUSE_UNDEF;
		end else if (swiInstr) begin
			cause = `AEE_CAUSE_SWI;
		end
	end

	always @* begin
		case (state)
			ST_RESET: next_state = ST_ENTER;
			ST_RUN: begin
				if (execEnd && cause != `AEE_CAUSE_NONE) begin
					next_state = ST_ENTER;
				end else begin
					next_state = ST_RUN;
				end
			end
			ST_ENTER: next_state = ST_RUN;
			default:  next_state = ST_RUN;
		endcase
	end

	// fetch abort tags travel with the instruction through the pipeline
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tagDecode   <= 1'b0;
			execInvalid <= 1'b0;
		end else begin
			if (pipeFlush) begin
				tagDecode   <= 1'b0; // RULE4
				execInvalid <= 1'b0;
			end else if (pipeAdvance) begin
				execInvalid <= tagDecode;
				tagDecode   <= 1'b0;
			end
			if (abortSample && cycleFetch) begin
				tagDecode <= 1'b1; // RULE3
			end
		end
	end

	// per-instruction abort and address state
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			addrExc        <= 1'b0;
			dataAbort      <= 1'b0;
			suppressWrites <= 1'b0;
			baseWbAllow    <= 1'b1;
			storeToLoad    <= 1'b0;
		end else if (execEnd) begin
			addrExc        <= 1'b0;
			dataAbort      <= 1'b0;
			suppressWrites <= 1'b0;
			baseWbAllow    <= 1'b1;
			storeToLoad    <= 1'b0;
		end else begin
			if (addrIllegal) begin
				addrExc     <= 1'b1;
				storeToLoad <= 1'b1; // RULE14
			end
			if (dataAbortNow) begin
				dataAbort      <= 1'b1;
				suppressWrites <= 1'b1; // RULE7
				if (classSingle) begin
					baseWbAllow <= 1'b0; // RULE5
				end else if (classMultiple) begin
					baseWbAllow <= 1'b1; // RULE6
				end
			end
		end
	end

	// entry actions and the register bus share mode and mask state
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state         <= ST_RESET;
			lastCause     <= `AEE_CAUSE_NONE;
			linkWrite     <= 1'b0;
			linkBank      <= `AEE_MODE_SVC;
			linkValue     <= 32'h00000000;
			pcLoad        <= 1'b0;
			pcValue       <= `AEE_VEC_RESET;
			modeOut       <= `AEE_MODE_SVC;
			iMask         <= 1'b1;
			fMask         <= 1'b1;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AEE_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `AEE_RESP_OKAY;
			awHeld        <= 1'b0;
			wHeld         <= 1'b0;
			awAddrQ       <= 4'h0;
			wDataQ        <= 32'h00000000;
			wStrbQ        <= 4'h0;
		end else begin
			state     <= next_state;
			linkWrite <= 1'b0;
			pcLoad    <= 1'b0;

			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awHeld        <= 1'b1;
				awAddrQ       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wHeld        <= 1'b1;
				wDataQ       <= s_axi_wdata;
				wStrbQ       <= s_axi_wstrb;
			end
			if (awHeld && wHeld && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				if (awAddrQ == `AEE_OFF_CTRL) begin
					s_axi_bresp <= `AEE_RESP_OKAY;
					if (wStrbQ[0]) begin
						iMask   <= wDataQ[`AEE_CTRL_I];
						fMask   <= wDataQ[`AEE_CTRL_F];
						modeOut <= wDataQ[`AEE_CTRL_M_HI:`AEE_CTRL_M_LO];
					end
				end else if (awAddrQ == `AEE_OFF_STATUS ||
					awAddrQ == `AEE_OFF_LINK) begin
					s_axi_bresp <= `AEE_RESP_OKAY;
				end else begin
					s_axi_bresp <= `AEE_RESP_DECERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				awHeld        <= 1'b0;
				wHeld         <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end

			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `AEE_RESP_OKAY;
				s_axi_rdata   <= 32'h00000000;
				case (s_axi_araddr)
					`AEE_OFF_CTRL: begin
						s_axi_rdata[`AEE_CTRL_I] <= iMask;
						s_axi_rdata[`AEE_CTRL_F] <= fMask;
						s_axi_rdata[`AEE_CTRL_M_HI:`AEE_CTRL_M_LO] <= modeOut;
					end
					`AEE_OFF_STATUS: begin
						s_axi_rdata[`AEE_ST_CAUSE_HI:`AEE_ST_CAUSE_LO] <= lastCause;
						s_axi_rdata[`AEE_ST_ADDR] <= addrExc;
						s_axi_rdata[`AEE_ST_DABT] <= dataAbort;
						s_axi_rdata[`AEE_ST_FIQ]  <= !fiqLevelN;
						s_axi_rdata[`AEE_ST_IRQ]  <= !irqLevelN;
						s_axi_rdata[`AEE_ST_M_HI:`AEE_ST_M_LO] <= modeOut;
						s_axi_rdata[`AEE_ST_I] <= iMask;
						s_axi_rdata[`AEE_ST_F] <= fMask;
					end
					`AEE_OFF_LINK: begin
						s_axi_rdata <= linkValue;
					end
					default: begin
						s_axi_rresp <= `AEE_RESP_DECERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end

			// hardware entry overrides a software write of mode and normal mask in the same cycle, and of fast mask on reset or fast entry only
			case (state)
				ST_RESET: begin
					linkWrite <= 1'b1; // RULE9
					linkBank  <= `AEE_MODE_SVC;
					linkValue <= cswIn;
					pcLoad    <= 1'b1;
					pcValue   <= `AEE_VEC_RESET;
					modeOut   <= `AEE_MODE_SVC;
					iMask     <= 1'b1;
					fMask     <= 1'b1;
					lastCause <= `AEE_CAUSE_RESET;
				end
				ST_RUN: begin
					if (execEnd && cause != `AEE_CAUSE_NONE) begin
						linkWrite <= 1'b1; // RULE10 RULE11 RULE12 RULE13
						linkBank  <= modeFor(cause); // RULE16 RULE17
						linkValue <= linkFor(cswIn, cause);
						pcLoad    <= 1'b1;
						pcValue   <= vectorFor(cause); // RULE15
						modeOut   <= modeFor(cause); // RULE23
						iMask     <= 1'b1;
						if (cause == `AEE_CAUSE_FIQ) begin
							fMask <= 1'b1; // RULE17
						end
						lastCause <= cause;
					end
				end
				default: lastCause <= lastCause;
			endcase
		end
	end
endmodule // aee_exception_entry

// [verification/aee_entry_chk.sv]
// checker for the exception entry unit, bound to its top module
// assumes one clock core_clk and an asynchronous active-low nrst
`timescale 1ns/1ps
module aee_entry_chk (
	input wire        core_clk,       // clock
	input wire        nrst,           // reset, low
	input wire        phase1End,      // bus phase end
	input wire        abortIn,        // abort
	input wire        cycleFetch,     // fetch cycle
	input wire        cycleData,      // data cycle
	input wire        execEnd,        // last exec cycle
	input wire        execInvalid,    // tagged instr
	input wire        undefInstr,     // undefined
	input wire        swiInstr,       // software trap
	input wire        classSingle,    // single transfer
	input wire        classMultiple,  // multiple transfer
	input wire        addrValid,      // address present
	input wire [31:0] dataAddr,       // data address
	input wire [31:0] cswIn,          // status word
	input wire        suppressWrites, // write block
	input wire        baseWbAllow,    // base write-back
	input wire        storeToLoad,    // store as load
	input wire        pcLoad,         // counter load
	input wire [25:0] pcValue,        // vector
	input wire [1:0]  linkBank,       // link bank
	input wire [31:0] linkValue,      // link value
	input wire [1:0]  modeOut,        // mode
	input wire        iMask,          // normal mask
	input wire        fMask           // fast mask
);
	reg  [31:0] cswPrev;
	wire        bad   = addrValid && |dataAddr[31:26];
	wire        quiet = !suppressWrites && !execEnd;
	wire        abtD  = phase1End && abortIn && cycleData && !bad && !storeToLoad && !execEnd;
	// status word as the unit sampled it at the deciding edge
	always @(posedge core_clk)
		cswPrev <= cswIn;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_dabt_block: assert property (abtD |=> suppressWrites)
		else $error("write block missing");
	a_single_nowb: assert property (abtD && classSingle |=> !baseWbAllow)
		else $error("single transfer kept write-back");
	a_multi_wb: assert property (abtD && classMultiple |=> baseWbAllow)
		else $error("multiple transfer lost write-back");
	a_internal_ign: assert property (
		phase1End && abortIn && !cycleFetch && !cycleData && quiet |=> !suppressWrites)
		else $error("internal cycle abort taken");
	a_illegal_ign: assert property (
		phase1End && abortIn && cycleData && bad && quiet |=> storeToLoad && !suppressWrites)
		else $error("abort not ignored on illegal address");
	a_dabt_vec: assert property (
		execEnd && suppressWrites |=> pcLoad && pcValue == 26'h10
		&& linkValue == cswPrev && modeOut == 2'h3 && iMask)
		else $error("data abort entry wrong");
	a_trap_entry: assert property (
		execEnd && (undefInstr || swiInstr || execInvalid) |=> pcLoad)
		else $error("trap not entered");
	a_undef_link: assert property (
		pcLoad && pcValue inside {26'h4, 26'h8, 26'hC}
		|-> linkValue[25:2] == cswPrev[25:2] - 24'h1 && linkBank == 2'h3)
		else $error("trap link wrong");
	a_fiq_entry: assert property (
		pcLoad && pcValue == 26'h1C |-> modeOut == 2'h1 && iMask && fMask && linkBank == 2'h1)
		else $error("fast entry wrong");
	a_reset_entry: assert property (
		pcLoad && pcValue == 26'h0 |-> iMask && fMask && modeOut == 2'h3 && linkBank == 2'h3)
		else $error("reset entry wrong");
	c_dabt: cover property (abtD);
	c_fiq: cover property (pcLoad && pcValue == 26'h1C);
	c_pabt: cover property (execEnd && execInvalid);
endmodule // aee_entry_chk

bind aee_exception_entry aee_entry_chk aee_entry_chk_inst (.*);

// [verification/aee_mmu_model.sv]
// memory manager and interrupt sources facing the entry unit
// assumes the bench names a missing page and raises interrupt requests
`timescale 1ns/1ps
module aee_mmu_model (
	input  wire core_clk,  // processor clock
	input  wire phase1End, // end of first bus phase
	input  wire pageGone,  // accessed page not resident
	input  wire fiqReq,    // fast request
	input  wire irqReq,    // normal request
	output wire abortIn,   // abort to the core
	output reg  fiqPinN,   // fast pin, active low
	output reg  irqPinN    // normal pin, active low
);
	assign abortIn = phase1End && pageGone;
	// pins move off the clock edge, as from an unrelated source
	always @(posedge core_clk) begin
		fiqPinN <= #37 !fiqReq;
		irqPinN <= #37 !irqReq;
	end
endmodule // aee_mmu_model

// [verification/tb_top.sv]
// self-checking bench for the exception entry unit with its partner model
// assumes the unit's map header on the include path
`timescale 1ns/1ps
`include "aee_map.vh"
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin errTotal++; \
	$display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module tb_top;
	typedef struct packed {
		logic [3:0] ab;
		logic       sgl, ill, flush, rsv;
		logic       und, software_trap_instr, irq, fiq;
		logic [7:0] vec;
		logic [1:0] mode, bank;
		logic       ld, dec, fm, rsv2;
	} aee_row_t;
	logic        core_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, dataAddr, cswIn, linkValue;
	logic [1:0]  s_axi_bresp, s_axi_rresp, linkBank, modeOut;
	logic [25:0] pcValue;
	logic        fiqPinN, irqPinN, abortIn, phase1End, cycleFetch, cycleData, pipeAdvance;
	logic        pipeFlush, execEnd, classSingle, classMultiple, undefInstr, swiInstr;
	logic        addrValid, execInvalid, suppressWrites, baseWbAllow, storeToLoad;
	logic        linkWrite, pcLoad, iMask, fMask, pageGone, fiqReq, irqReq;
	int          errTotal, nCompared;
	// hex digits: kind, single/illegal/flush, undef/swi/irq/fiq, vector, mode/bank, load/dec/fmask
	aee_row_t rows[15] = '{28'h00804FC, 28'h00408FC, 28'h1000CFC, 28'h1200000, 28'h28010F8,
		28'h20010F8, 28'h24014F8, 28'h44014F8, 28'h3000000, 28'h00218A8, 28'h0011C5A,
		28'h0031C5A, 28'h1080CFC, 28'h00618A8, 28'h28810F8};

	aee_exception_entry aee_exception_entry_inst (.*);
	aee_mmu_model aee_mmu_model_inst (.*);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task tally_and_finish;
		if (errTotal == 0 && nCompared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#(5000 * 100);
		errTotal++;
		tally_and_finish;
	end

	task automatic axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask

	task automatic axi_rd(input [3:0] a, input [31:0] ed, input [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, ed)
		`CHK(s_axi_rresp, er)
	endtask

	// one instruction: optional bus cycle, advance or flush, then its last cycle
	task automatic run_row(input aee_row_t r);
		logic dab;
		dab = r.ab == 2 && !r.ill;
		axi_wr(`AEE_OFF_CTRL, 32'h0, `AEE_RESP_OKAY);
		fiqReq <= r.fiq;
		irqReq <= r.irq;
		cswIn <= cswIn + 32'h40;
		repeat (8) @(posedge core_clk);
		phase1End <= r.ab != 0;
		cycleFetch <= r.ab == 1;
		cycleData <= r.ab == 2 || r.ab == 4;
		pageGone <= r.ab inside {1, 2, 3};
		addrValid <= r.ab == 2 || r.ab == 4;
		dataAddr <= r.ill ? 32'h04000100 : 32'h00000100;
		classSingle <= r.sgl;
		classMultiple <= !r.sgl;
		@(posedge core_clk);
		{phase1End, cycleFetch, cycleData, pageGone, addrValid} <= '0;
		pipeAdvance <= !r.flush;
		pipeFlush <= r.flush;
		#1;
		`CHK(suppressWrites, dab)
		`CHK(baseWbAllow, !(dab && r.sgl))
		`CHK(storeToLoad, r.ill)
		@(posedge core_clk);
		{pipeAdvance, pipeFlush} <= '0;
		execEnd <= 1'b1;
		undefInstr <= r.und;
		swiInstr <= r.software_trap_instr;
		#1;
		`CHK(execInvalid, r.ab == 1 && !r.flush)
		@(posedge core_clk);
		{execEnd, undefInstr, swiInstr} <= '0;
		#1;
		`CHK(pcLoad, r.ld)
		`CHK(linkWrite, r.ld)
		`CHK(modeOut, r.mode)
		`CHK(iMask, r.ld)
		`CHK(fMask, r.fm)
		if (r.ld) begin
			`CHK(pcValue, {18'h0, r.vec})
			`CHK(linkBank, r.bank)
			`CHK(linkValue, cswIn - (r.dec ? 32'h4 : 32'h0))
		end
		`CHK(suppressWrites, 1'b0)
	endtask

	initial begin
		{nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
			s_axi_awaddr, s_axi_araddr, s_axi_wdata, phase1End, cycleFetch, cycleData,
			pipeAdvance, pipeFlush, execEnd, classSingle, classMultiple, undefInstr,
			swiInstr, addrValid, dataAddr, pageGone, fiqReq, irqReq} = '0;
		s_axi_wstrb = 4'hF;
		cswIn = 32'h400;
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			run_row(rows[i]);
			fiqReq <= 1'b0;
			irqReq <= 1'b0;
			repeat (8) @(posedge core_clk);
		end
		// data abort and fast request together: abort first, fast entry next
		run_row(28'h28110F8);
		@(posedge core_clk);
		execEnd <= 1'b1;
		@(posedge core_clk);
		execEnd <= 1'b0;
		#1;
		`CHK(pcValue, 26'h1C)
		`CHK(modeOut, `AEE_MODE_FIQ)
		fiqReq <= 1'b0;
		axi_rd(`AEE_OFF_LINK, cswIn, `AEE_RESP_OKAY);
		axi_rd(`AEE_OFF_CTRL, 32'h00000007, `AEE_RESP_OKAY);
		// no strobe on the low byte leaves the control bits alone
		s_axi_wstrb <= 4'hE;
		axi_wr(`AEE_OFF_CTRL, 32'h00000000, `AEE_RESP_OKAY);
		axi_rd(`AEE_OFF_CTRL, 32'h00000007, `AEE_RESP_OKAY);
		axi_rd(4'hC, 32'h00000000, `AEE_RESP_DECERR);
		axi_wr(4'hC, 32'h00000005, `AEE_RESP_DECERR);
		// reset in mid-run, then the entry on release
		@(posedge core_clk);
		nrst <= 1'b0;
		#1;
		`CHK({modeOut, iMask, fMask, pcLoad}, 5'b11110)
		@(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		#1;
		`CHK({pcLoad, linkWrite, linkBank, pcValue}, {1'b1, 1'b1, 2'h3, 26'h0})
		`CHK(linkValue, cswIn)
		axi_rd(`AEE_OFF_STATUS, 32'h00000F01, `AEE_RESP_OKAY);
		tally_and_finish;
	end
endmodule // tb_top
